// ### core/rcdar_consts.svh
// constants of the remote data access router: station codes, answer codes, timing
`ifndef RCDAR_CONSTS_SVH
`define RCDAR_CONSTS_SVH

// target station number encodings
`define RCDAR_TSN_SELF 8'hFF
`define RCDAR_TSN_MASTER 8'h00
`define RCDAR_TSN_MAX 8'h40

// station role of the device on the station link
`define RCDAR_ROLE_ALONE 2'h0
`define RCDAR_ROLE_MASTER 2'h1
`define RCDAR_ROLE_LOCAL 2'h2

// completion codes carried back to the remote node
`define RCDAR_CC_OK 8'h00
`define RCDAR_CC_WR_REFUSED 8'hA1
`define RCDAR_CC_NO_ROUTE 8'hA2
`define RCDAR_CC_REMOTE_IO 8'hA3
`define RCDAR_CC_HOST_FAIL 8'hA4

// scan multipliers of a forwarded exchange
`define RCDAR_SCANS_FIRST 6'h03
`define RCDAR_SCANS_NORMAL 6'h01

// link instruction processing time and its cycle count at 50 MHz
`define RCDAR_CLK_PERIOD_NS 20
`define RCDAR_INSTR_TIME_NS 1000
`define RCDAR_INSTR_CYCLES \
    ((`RCDAR_INSTR_TIME_NS + `RCDAR_CLK_PERIOD_NS - 1) / `RCDAR_CLK_PERIOD_NS)

`endif

// ### core/rcdar_pkg.sv
// types of the remote data access router
package rcdar_pkg;

    typedef enum logic [2:0] {
        RCDAR_IDLE = 3'b000,
        RCDAR_WAIT_HOST = 3'b001,
        RCDAR_FWD_INSTR = 3'b010,
        RCDAR_FWD_SCAN = 3'b011,
        RCDAR_RESPOND = 3'b100
    } rcdar_state_t;

endpackage

// ### core/rcdar_router.sv
// remote data access router: checks, routes and answers remote device memory access
//
// How it works
// - access served regardless of handshake or program
// - switch off, host running: refuse writes
// - switch on: writes accepted, run or stop
// - each command that passes the write, route and remote checks raises one host access request
// - host result returned to node as response
// - FF self, 00 master, 01-40 stations
// - only self, master-local pairs are reachable
// - remote station: special module buffer only
// - local latency: instruction plus scans, first 3
// - remote latency: instruction plus master scan
// - two-scan command doubles the latency
// - each tool monitor session doubles latency
`timescale 1ns/10ps
`include "rcdar_consts.svh"

module rcdar_router #(
    parameter int ADDR_W = 16,
    parameter int DATA_W = 16,
    parameter int INSTR_CYCLES = `RCDAR_INSTR_CYCLES
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic run_write_enable_switch,
    input wire logic host_running,
    input wire logic [1:0] station_role,
    input wire logic [1:0] monitor_sessions,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire logic cmd_write,
    input wire logic [7:0] cmd_target_station_number,
    input wire logic cmd_remote_io,
    input wire logic cmd_buffer_access,
    input wire logic cmd_two_scan,
    input wire logic [ADDR_W-1:0] cmd_addr,
    input wire logic [DATA_W-1:0] cmd_wdata,
    output logic host_req_valid,
    output logic host_req_write,
    output logic [7:0] host_req_station,
    output logic [ADDR_W-1:0] host_req_addr,
    output logic [DATA_W-1:0] host_req_wdata,
    input wire logic host_done,
    input wire logic host_error,
    input wire logic [DATA_W-1:0] host_rdata,
    input wire logic host_scan_end,
    output logic rsp_valid,
    input wire logic rsp_ready,
    output logic [7:0] rsp_code,
    output logic [DATA_W-1:0] rsp_data
);

    ////////////////////////////////////////////////////////////////////////////
    // state

    typedef struct packed {
        rcdar_pkg::rcdar_state_t st;
        logic first;
        logic wr;
        logic fwd;
        logic [7:0] tsn;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic [7:0] code;
        logic [DATA_W-1:0] rdata;
        logic [5:0] need;
        logic [5:0] scans;
        logic [15:0] icnt;
    } rcdar_regs_t;

    rcdar_regs_t r_q;
    rcdar_regs_t r_d;

    logic accept;
    logic reach_ok;
    logic refuse_wr;
    logic [7:0] deny_code;
    logic [5:0] base_scans;
    logic [2:0] shift_amt;

    ////////////////////////////////////////////////////////////////////////////
    // decode of an arriving command

    // handshakes are combinational; the node sees ready only while idle
    // single request outstanding
    assign cmd_ready = (r_q.st == rcdar_pkg::RCDAR_IDLE);
    assign accept = cmd_valid && cmd_ready;

    // reachability of the target station from this station's role
    always_comb begin
        reach_ok = 1'b0;
        if (cmd_target_station_number == `RCDAR_TSN_SELF) begin
            reach_ok = 1'b1;
        end else if (station_role == `RCDAR_ROLE_LOCAL) begin
            reach_ok = (cmd_target_station_number == `RCDAR_TSN_MASTER);
        end else if (station_role == `RCDAR_ROLE_MASTER) begin
            reach_ok = (cmd_target_station_number != `RCDAR_TSN_MASTER) &&
                       (cmd_target_station_number <= `RCDAR_TSN_MAX);
        end
    end

    assign refuse_wr = cmd_write && host_running && !run_write_enable_switch;

    // completion code of a refused command; write check takes precedence
    always_comb begin
        deny_code = `RCDAR_CC_OK;
        if (refuse_wr) begin
            deny_code = `RCDAR_CC_WR_REFUSED;
        end else if (!reach_ok) begin
            deny_code = `RCDAR_CC_NO_ROUTE;
        end else if (cmd_remote_io && !cmd_buffer_access &&
                     cmd_target_station_number != `RCDAR_TSN_SELF) begin
            deny_code = `RCDAR_CC_REMOTE_IO;
        end
    end

    // scans a forwarded exchange waits; first exchange after reset is slow
    // first exchange uses three
    assign base_scans = r_q.first ? `RCDAR_SCANS_FIRST : `RCDAR_SCANS_NORMAL;
    assign shift_amt = {2'b00, cmd_two_scan} + {1'b0, monitor_sessions};

    ////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        r_d = r_q;
        case (r_q.st)
            rcdar_pkg::RCDAR_IDLE: begin
                if (accept) begin
                    r_d.wr = cmd_write;
                    r_d.tsn = cmd_target_station_number;
                    r_d.addr = cmd_addr;
                    r_d.wdata = cmd_wdata;
                    r_d.fwd = (cmd_target_station_number != `RCDAR_TSN_SELF);
                    r_d.need = base_scans << shift_amt;
                    r_d.scans = 6'h00;
                    r_d.icnt = 16'h0000;
                    r_d.rdata = '0;
                    r_d.code = deny_code;
                    if (deny_code == `RCDAR_CC_OK) begin
                        r_d.st = rcdar_pkg::RCDAR_WAIT_HOST;
                    end else begin
                        r_d.st = rcdar_pkg::RCDAR_RESPOND;
                    end
                end
            end
            rcdar_pkg::RCDAR_WAIT_HOST: begin
                if (host_done) begin
                    r_d.rdata = host_error ? '0 : host_rdata;
                    r_d.code = host_error ? `RCDAR_CC_HOST_FAIL : `RCDAR_CC_OK;
                    if (r_q.fwd && !host_error) begin
                        r_d.st = rcdar_pkg::RCDAR_FWD_INSTR;
                    end else begin
                        r_d.st = rcdar_pkg::RCDAR_RESPOND;
                    end
                end
            end
            rcdar_pkg::RCDAR_FWD_INSTR: begin
                r_d.icnt = r_q.icnt + 16'h0001;
                if (r_q.icnt >= 16'(INSTR_CYCLES - 1)) begin
                    r_d.st = rcdar_pkg::RCDAR_FWD_SCAN;
                end
            end
            rcdar_pkg::RCDAR_FWD_SCAN: begin
                // scan count is taken from host end-of-scan pulses only
                if (host_scan_end) begin
                    r_d.scans = r_q.scans + 6'h01;
                    if (r_q.scans + 6'h01 >= r_q.need) begin
                        r_d.st = rcdar_pkg::RCDAR_RESPOND;
                        r_d.first = 1'b0;
                    end
                end
            end
            rcdar_pkg::RCDAR_RESPOND: begin
                if (rsp_ready) begin
                    r_d.st = rcdar_pkg::RCDAR_IDLE;
                end
            end
            default: begin
                r_d.st = rcdar_pkg::RCDAR_IDLE;
            end
        endcase
    end

    // state register; the first-exchange flag is set by every reset
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            r_q <= '{st: rcdar_pkg::RCDAR_IDLE, first: 1'b1, default: '0};
        end else begin
            r_q <= r_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    assign host_req_valid = (r_q.st == rcdar_pkg::RCDAR_WAIT_HOST);
    assign host_req_write = r_q.wr;
    assign host_req_station = r_q.tsn;
    assign host_req_addr = r_q.addr;
    assign host_req_wdata = r_q.wdata;
    assign rsp_valid = (r_q.st == rcdar_pkg::RCDAR_RESPOND);
    assign rsp_code = r_q.code;
    assign rsp_data = r_q.rdata;

    ////////////////////////////////////////////////////////////////////////////
    // assertions

    property p_wr_refused;
        @(posedge clock) disable iff (rst)
        accept && cmd_write && host_running && !run_write_enable_switch
        |=> rsp_valid && rsp_code == `RCDAR_CC_WR_REFUSED && !host_req_valid;
    endproperty
    a_wr_refused: assert property (p_wr_refused)
        else $error("write while running not refused");

    property p_wr_allowed;
        @(posedge clock) disable iff (rst)
        accept && cmd_write && run_write_enable_switch &&
        cmd_target_station_number == `RCDAR_TSN_SELF
        |=> host_req_valid && host_req_write;
    endproperty
    a_wr_allowed: assert property (p_wr_allowed)
        else $error("enabled write did not reach the host");

    property p_req_issued;
        @(posedge clock) disable iff (rst)
        accept && deny_code == `RCDAR_CC_OK
        |=> host_req_valid && host_req_station == $past(cmd_target_station_number);
    endproperty
    a_req_issued: assert property (p_req_issued)
        else $error("accepted command raised no host request");

    property p_self_answer;
        @(posedge clock) disable iff (rst)
        host_req_valid && host_done && !host_error && host_req_station == `RCDAR_TSN_SELF
        |=> rsp_valid && rsp_code == `RCDAR_CC_OK && rsp_data == $past(host_rdata);
    endproperty
    a_self_answer: assert property (p_self_answer)
        else $error("host result not returned");

    property p_peer_local;
        @(posedge clock) disable iff (rst)
        accept && station_role == `RCDAR_ROLE_LOCAL && !refuse_wr &&
        cmd_target_station_number inside {[8'h01:8'h40]}
        |=> rsp_valid && rsp_code == `RCDAR_CC_NO_ROUTE;
    endproperty
    a_peer_local: assert property (p_peer_local)
        else $error("peer local station reached");

    property p_remote_io;
        @(posedge clock) disable iff (rst)
        accept && reach_ok && !refuse_wr && cmd_remote_io && !cmd_buffer_access &&
        cmd_target_station_number != `RCDAR_TSN_SELF
        |=> rsp_code == `RCDAR_CC_REMOTE_IO ##0 rsp_valid;
    endproperty
    a_remote_io: assert property (p_remote_io)
        else $error("remote station device access not restricted");

    // busy stays busy until the node has taken the answer
    property p_one_outstanding;
        @(posedge clock) disable iff (rst)
        !cmd_ready && !(rsp_valid && rsp_ready) |=> !cmd_ready;
    endproperty
    a_one_outstanding: assert property (p_one_outstanding)
        else $error("command taken while request outstanding");

    property p_first_three;
        @(posedge clock) disable iff (rst)
        accept && r_q.first && !cmd_two_scan && monitor_sessions == 2'h0
        |=> r_q.need == 6'h03;
    endproperty
    a_first_three: assert property (p_first_three)
        else $error("first exchange multiplier wrong");

    property p_double;
        @(posedge clock) disable iff (rst)
        accept && !r_q.first && cmd_two_scan && monitor_sessions == 2'h1
        |=> r_q.need == 6'h04;
    endproperty
    a_double: assert property (p_double)
        else $error("two-scan or monitor doubling wrong");

    property p_fwd_wait;
        @(posedge clock) disable iff (rst)
        r_q.st == rcdar_pkg::RCDAR_FWD_SCAN && !host_scan_end |=> !rsp_valid;
    endproperty
    a_fwd_wait: assert property (p_fwd_wait)
        else $error("forwarded answer sent without scan");

    c_self_read: cover property (@(posedge clock) disable iff (rst)
        accept && !cmd_write ##[1:50] rsp_valid && rsp_code == `RCDAR_CC_OK);
    c_refused: cover property (@(posedge clock) disable iff (rst)
        rsp_valid && rsp_code == `RCDAR_CC_WR_REFUSED);
    c_forward: cover property (@(posedge clock) disable iff (rst)
        r_q.st == rcdar_pkg::RCDAR_FWD_SCAN ##1 rsp_valid);

endmodule

// ### tb/rcdar_host_model.sv
// behavioural host controller facing the router's host request side
`timescale 1ns/10ps

module rcdar_host_model #(
    parameter int SCAN = 7
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic req_valid,
    input wire logic [15:0] req_addr,
    input wire logic fail,
    output logic done,
    output logic error,
    output logic [15:0] rdata,
    output logic scan_end
);
    int cnt;

    ////////////////////////////////////////////////////////////////////////
    // scan ticker and request service
    // service after scan end
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cnt <= 0;
            scan_end <= 1'b0;
            done <= 1'b0;
        end else begin
            cnt <= (cnt == SCAN - 1) ? 0 : cnt + 1;
            scan_end <= (cnt == SCAN - 1);
            done <= req_valid && scan_end && !done;
        end
    end

    // data is only valid with done; otherwise a moving pattern
    assign error = done && fail;
    assign rdata = done ? (req_addr ^ 16'h5A5A) : 16'(cnt * 16'h3C1);
endmodule

// ### tb/remote_cpu_data_access_router_test.sv
// self-checking bench of the remote data access router
`timescale 1ns/10ps
`include "rcdar_consts.svh"

module remote_cpu_data_access_router_test;
    localparam int INSTR = 2;
    logic clock = 1'b0, rst = 1'b1, sw = 1'b0, running = 1'b0, fail = 1'b0;
    logic cmd_valid = 1'b0, cmd_write = 1'b0, rio = 1'b0, bufa = 1'b0, two = 1'b0;
    logic rsp_ready = 1'b0, cmd_ready, req_valid, req_write, done, error, scan_end, rsp_valid;
    logic [1:0] role = 2'h0, mon = 2'h0;
    logic [7:0] tsn = 8'hFF, req_station, rsp_code;
    logic [15:0] addr = 16'h0, wdata = 16'h0, req_addr, req_wdata, rdata, rsp_data;
    logic [31:0] seed = 32'hFF03;
    logic first = 1'b1;
    logic [7:0] exp_code_q[$];
    int error_cnt = 0, n_checks = 0, cycles = 0;

    rcdar_router #(.INSTR_CYCLES(INSTR)) dut (.clock(clock), .rst(rst),
        .run_write_enable_switch(sw), .host_running(running), .station_role(role),
        .monitor_sessions(mon), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
        .cmd_write(cmd_write), .cmd_target_station_number(tsn), .cmd_remote_io(rio),
        .cmd_buffer_access(bufa), .cmd_two_scan(two), .cmd_addr(addr), .cmd_wdata(wdata),
        .host_req_valid(req_valid), .host_req_write(req_write), .host_req_station(req_station),
        .host_req_addr(req_addr), .host_req_wdata(req_wdata), .host_done(done),
        .host_error(error), .host_rdata(rdata), .host_scan_end(scan_end),
        .rsp_valid(rsp_valid), .rsp_ready(rsp_ready), .rsp_code(rsp_code), .rsp_data(rsp_data));

    rcdar_host_model host (.clock(clock), .rst(rst), .req_valid(req_valid), .req_addr(req_addr),
        .fail(fail), .done(done), .error(error), .rdata(rdata), .scan_end(scan_end));

    always #10 clock = ~clock;

    ////////////////////////////////////////////////////////////////////////
    // helpers
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("FAIL at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // hang guard, well above the longest expected run
    always @(posedge clock) begin
        cycles++;
        if (cycles == 60000) begin
            error_cnt++;
            test_done();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // one random command, modelled and compared end to end
    task automatic run_cmd();
        logic [31:0] r;
        logic [7:0] code;
        logic fwd, reach, seen_req, seen_done;
        int need, pulses, gap, waits;
        r = rnd();
        case (r[2:0])
            3'h0: tsn = `RCDAR_TSN_MASTER;
            3'h1: tsn = 8'h01;
            3'h2: tsn = `RCDAR_TSN_MAX;
            3'h3: tsn = 8'h41;
            3'h4: tsn = r[31:24];
            default: tsn = `RCDAR_TSN_SELF;
        endcase
        role = (r[4:3] == 2'h3) ? `RCDAR_ROLE_MASTER : r[4:3];
        mon = r[6:5];
        cmd_write = r[7];
        running = r[8];
        sw = r[9];
        rio = r[10];
        bufa = r[11];
        two = r[12];
        fail = r[13] && r[14] && tsn == `RCDAR_TSN_SELF;
        // switch usually on for remote station writes
        if (rio && cmd_write && r[15]) sw = 1'b1;
        addr = r[31:16];
        wdata = 16'(rnd() >> 7);
        reach = tsn == `RCDAR_TSN_SELF || (role == `RCDAR_ROLE_LOCAL && tsn == `RCDAR_TSN_MASTER)
            || (role == `RCDAR_ROLE_MASTER && tsn >= 8'h01 && tsn <= `RCDAR_TSN_MAX);
        if (cmd_write && running && !sw) code = `RCDAR_CC_WR_REFUSED;
        else if (!reach) code = `RCDAR_CC_NO_ROUTE;
        else if (rio && !bufa && tsn != `RCDAR_TSN_SELF) code = `RCDAR_CC_REMOTE_IO;
        else code = fail ? `RCDAR_CC_HOST_FAIL : `RCDAR_CC_OK;
        exp_code_q.push_back(code);
        fwd = code == `RCDAR_CC_OK && tsn != `RCDAR_TSN_SELF;
        need = int'(first ? `RCDAR_SCANS_FIRST : `RCDAR_SCANS_NORMAL) << (int'(two) + int'(mon));
        cmd_valid = 1'b1;
        check(16'(cmd_ready), 16'h1);
        @(negedge clock);
        cmd_valid = 1'b0;
        gap = 1;
        pulses = 0;
        waits = 0;
        seen_req = 1'b0;
        seen_done = 1'b0;
        while (rsp_valid !== 1'b1 && waits < 3000) begin
            check(16'(cmd_ready), 16'h0);
            if (req_valid === 1'b1 && !seen_req) begin
                seen_req = 1'b1;
                check(16'(req_station), 16'(tsn));
                check(req_addr, addr);
                check(16'(req_write), 16'(cmd_write));
                if (cmd_write) check(req_wdata, wdata);
            end
            gap++;
            if (done === 1'b1 && req_valid === 1'b1) begin
                seen_done = 1'b1;
                gap = 1;
            end else if (seen_done && scan_end === 1'b1) begin
                pulses++;
                gap = 1;
            end
            @(negedge clock);
            waits++;
        end
        check(16'(rsp_valid), 16'h1);
        check(16'(rsp_code), 16'(exp_code_q.pop_front()));
        check(16'(gap), 16'h1);
        check(16'(seen_req), 16'(code == `RCDAR_CC_OK || code == `RCDAR_CC_HOST_FAIL));
        if (code != `RCDAR_CC_OK) check(rsp_data, 16'h0);
        if (code == `RCDAR_CC_OK && !cmd_write) check(rsp_data, addr ^ 16'h5A5A);
        if (fwd) check(16'(pulses), 16'(need));
        if (fwd) first = 1'b0;
        repeat (rnd() % 32'h3) @(negedge clock);
        rsp_ready = 1'b1;
        @(negedge clock);
        rsp_ready = 1'b0;
        check(16'(cmd_ready), 16'h1);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // main sequence, with a second reset to rearm the first exchange
    initial begin
        repeat (12) @(negedge clock);
        rst = 1'b0;
        for (int i = 0; i < 80; i++) begin
            if (i == 40) begin
                rst = 1'b1;
                @(negedge clock);
                rst = 1'b0;
                first = 1'b1;
            end
            @(negedge clock);
            // idle after reset and between commands: ready, no request, no answer
            check(16'({cmd_ready, req_valid, rsp_valid}), 16'h4);
            run_cmd();
        end
        test_done();
    end
endmodule
